// ### tps_defines.vh
/*
 * Constants for the shared timer prescaler and tick-source block:
 * register offsets, field positions, reset values and tick-source codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TPS_DEFINES_VH
`define TPS_DEFINES_VH

// ----------------------------------------------------------------------
// Register map (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define TPS_OFF_SYNC_CTRL   4'h0
`define TPS_OFF_SRC_SEL     4'h4
`define TPS_OFF_STATUS      4'h8

// ----------------------------------------------------------------------
// Fields of general_timer_sync_control
// ----------------------------------------------------------------------
`define TPS_BIT_SHARED_RST  0
`define TPS_BIT_ASYNC_RST   1
`define TPS_BIT_HOLD_MODE   7
`define TPS_SYNC_CTRL_RST   8'h00

// ----------------------------------------------------------------------
// Fields of the tick-source select register
// ----------------------------------------------------------------------
`define TPS_SEL_A_LSB       0
`define TPS_SEL_B_LSB       4
`define TPS_SRC_SEL_RST     8'h00

// ----------------------------------------------------------------------
// Tick-source codes
// ----------------------------------------------------------------------
`define TPS_CS_STOP         3'h0
`define TPS_CS_DIRECT       3'h1
`define TPS_CS_DIV8         3'h2
`define TPS_CS_DIV64        3'h3
`define TPS_CS_DIV256       3'h4
`define TPS_CS_DIV1024      3'h5
`define TPS_CS_EXT_FALL     3'h6
`define TPS_CS_EXT_RISE     3'h7

// ----------------------------------------------------------------------
// Prescaler shape
// ----------------------------------------------------------------------
`define TPS_PRESC_WIDTH     10
`define TPS_TAP_DIV8        2
`define TPS_TAP_DIV64       5
`define TPS_TAP_DIV256      7
`define TPS_TAP_DIV1024     9

// AXI response codes
`define TPS_RESP_OKAY       2'h0
`define TPS_RESP_SLVERR     2'h2

`endif

// ### tps_tick_select.v
/*
 * One timer's tick selector: pin synchroniser, edge detector and
 * source multiplexer over the shared prescaler taps.
 * Assumes the prescaler and its tap strobes come from the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tps_defines.vh"

module tps_tick_select (
   input  wire       ref_clk,
   input  wire       rst_n,
   input  wire [2:0] tickSourceSelect,
   input  wire [3:0] tapStrobe,
   input  wire       prescalerHold,
   input  wire       extCountPin,
   output reg        timerTick,
   output wire       extPinSync
);

   reg       pinMeta;
   reg       pinSync;
   reg       pinLast;
   reg       next_timerTick;

   // ------------------------------------------------------------------
   // Synchroniser and edge detector
   // ------------------------------------------------------------------
   // The pin is sampled every cycle whatever the pin direction or mode,
   // so software driving the pin as an output still counts.
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         pinMeta <= 1'b0;
         pinSync <= 1'b0;
         pinLast <= 1'b0;
      end else begin
         pinMeta <= extCountPin;
         pinSync <= pinMeta;
         pinLast <= pinSync;
      end
   end

   assign extPinSync = pinSync;

   // ------------------------------------------------------------------
   // Source multiplexer
   // ------------------------------------------------------------------
   // The registered tick adds the last cycle of the pin-to-count delay;
   // external ticks never pass the prescaler.
   always @* begin
      case (tickSourceSelect)
         `TPS_CS_STOP:     next_timerTick = 1'b0;
         `TPS_CS_DIRECT:   next_timerTick = ~prescalerHold;
         `TPS_CS_DIV8:     next_timerTick = tapStrobe[0];
         `TPS_CS_DIV64:    next_timerTick = tapStrobe[1];
         `TPS_CS_DIV256:   next_timerTick = tapStrobe[2];
         `TPS_CS_DIV1024:  next_timerTick = tapStrobe[3];
         `TPS_CS_EXT_FALL: next_timerTick = pinLast & ~pinSync;
         `TPS_CS_EXT_RISE: next_timerTick = ~pinLast & pinSync;
         default:          next_timerTick = 1'b0;
      endcase
   end

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         timerTick <= 1'b0;
      end else begin
         timerTick <= next_timerTick;
      end
   end

endmodule
`default_nettype wire

// ### tps_prescaler_top.v
/*
 * Shared free-running prescaler and tick-source control for two timers,
 * with an AXI4-Lite register slave.
 * Assumes a single 50 MHz clock and a synchronous active-low reset; the
 * count pins arrive asynchronously and are synchronised here.
 */
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "tps_defines.vh"

module tps_prescaler_top #(
   parameter PRESC_WIDTH = `TPS_PRESC_WIDTH
) (
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        ext_count_pin_a,
   input  wire        ext_count_pin_b,
   output wire        timer_a_tick,
   output wire        timer_b_tick,
   output wire        async_prescaler_reset
);

   // ------------------------------------------------------------------
   // Control register state
   // ------------------------------------------------------------------
   reg                    timer_sync_hold_mode;
   reg                    shared_prescaler_reset;
   reg                    asyncResetBit;
   reg  [2:0]             selectA;
   reg  [2:0]             selectB;
   reg  [PRESC_WIDTH-1:0] prescaler;
   reg  [PRESC_WIDTH-1:0] next_prescaler;
   wire [3:0]             tapStrobe;
   wire                   pinSyncA;
   wire                   pinSyncB;

   // ------------------------------------------------------------------
   // AXI write channel state
   // ------------------------------------------------------------------
   reg        awHeld;
   reg  [3:0] awAddr;
   reg        wHeld;
   reg [31:0] wData;
   reg  [3:0] wStrb;
   wire       writeFire;

   assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
   assign writeFire     = awHeld & wHeld & ~s_axi_bvalid;

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         awAddr <= 4'h0;
         wHeld  <= 1'b0;
         wData  <= 32'h0000_0000;
         wStrb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end else if (writeFire) begin
            awHeld <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end else if (writeFire) begin
            wHeld <= 1'b0;
         end
      end
   end

   function mapped;
      input [3:0] addr;
      begin
         mapped = (addr == `TPS_OFF_SYNC_CTRL) || (addr == `TPS_OFF_SRC_SEL) ||
                  (addr == `TPS_OFF_STATUS);
      end
   endfunction

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `TPS_RESP_OKAY;
      end else if (writeFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(awAddr) ? `TPS_RESP_OKAY : `TPS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   wire ctrlWrite = writeFire && awAddr == `TPS_OFF_SYNC_CTRL && wStrb[0];
   wire selWrite  = writeFire && awAddr == `TPS_OFF_SRC_SEL && wStrb[0];

   // ------------------------------------------------------------------
   // Sync control and tick-source select
   // ------------------------------------------------------------------
   // Reset bits are pulses unless hold mode keeps them; a write that
   // clears hold mode releases both reset bits in the same cycle.
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         timer_sync_hold_mode   <= 1'b0;
         shared_prescaler_reset <= 1'b0;
         asyncResetBit          <= 1'b0;
      end else if (ctrlWrite) begin
         timer_sync_hold_mode   <= wData[`TPS_BIT_HOLD_MODE];
         shared_prescaler_reset <= wData[`TPS_BIT_SHARED_RST];
         asyncResetBit          <= wData[`TPS_BIT_ASYNC_RST];
         if (!wData[`TPS_BIT_HOLD_MODE]) begin
            shared_prescaler_reset <= wData[`TPS_BIT_SHARED_RST]
                                      & ~timer_sync_hold_mode;
            asyncResetBit          <= wData[`TPS_BIT_ASYNC_RST]
                                      & ~timer_sync_hold_mode;
         end
      end else if (!timer_sync_hold_mode) begin
         shared_prescaler_reset <= 1'b0;
         asyncResetBit          <= 1'b0;
      end
      // In hold mode with no write both bits keep their value
   end

   assign async_prescaler_reset = asyncResetBit;

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         selectA <= `TPS_CS_STOP;
         selectB <= `TPS_CS_STOP;
      end else if (selWrite) begin
         selectA <= wData[`TPS_SEL_A_LSB +: 3];
         selectB <= wData[`TPS_SEL_B_LSB +: 3];
      end
   end

   // ------------------------------------------------------------------
   // Shared prescaler
   // ------------------------------------------------------------------
   // Runs whatever either select says, so enabling a timer on a tap
   // lands its first tick anywhere from 1 to N cycles later.
   always @* begin
      if (shared_prescaler_reset) begin
         next_prescaler = {PRESC_WIDTH{1'b0}};
      end else begin
         next_prescaler = prescaler + {{(PRESC_WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         prescaler <= {PRESC_WIDTH{1'b0}};
      end else begin
         prescaler <= next_prescaler;
      end
   end

   // A tap strobes when all bits up to it are ones: one cycle per period
   genvar t;
   generate
      for (t = 0; t < 4; t = t + 1) begin : gTap
         localparam integer TAP = (t == 0) ? `TPS_TAP_DIV8 :
                                  (t == 1) ? `TPS_TAP_DIV64 :
                                  (t == 2) ? `TPS_TAP_DIV256 : `TPS_TAP_DIV1024;
         assign tapStrobe[t] = ~shared_prescaler_reset & (&prescaler[TAP:0]);
      end
   endgenerate

   // ------------------------------------------------------------------
   // Per-timer tick selection
   // ------------------------------------------------------------------
   tps_tick_select uSelA (
      .ref_clk          (ref_clk),
      .rst_n            (rst_n),
      .tickSourceSelect (selectA),
      .tapStrobe        (tapStrobe),
      .prescalerHold    (shared_prescaler_reset),
      .extCountPin      (ext_count_pin_a),
      .timerTick        (timer_a_tick),
      .extPinSync       (pinSyncA)
   );

   tps_tick_select uSelB (
      .ref_clk          (ref_clk),
      .rst_n            (rst_n),
      .tickSourceSelect (selectB),
      .tapStrobe        (tapStrobe),
      .prescalerHold    (shared_prescaler_reset),
      .extCountPin      (ext_count_pin_b),
      .timerTick        (timer_b_tick),
      .extPinSync       (pinSyncB)
   );

   // ------------------------------------------------------------------
   // AXI read channel
   // ------------------------------------------------------------------
   assign s_axi_arready = ~s_axi_rvalid;

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `TPS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= mapped(s_axi_araddr) ? `TPS_RESP_OKAY : `TPS_RESP_SLVERR;
         case (s_axi_araddr)
            `TPS_OFF_SYNC_CTRL: s_axi_rdata <= {24'h00_0000, timer_sync_hold_mode,
                                   5'h00, asyncResetBit, shared_prescaler_reset};
            `TPS_OFF_SRC_SEL:   s_axi_rdata <= {25'h000_0000, selectB, 1'b0, selectA};
            `TPS_OFF_STATUS:    s_axi_rdata <= {20'h0_0000, pinSyncB, pinSyncA,
                                   prescaler[9:0]};
            default:            s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ### tps_prescaler_sva.sv
/*
 * Checker for tps_prescaler_top: bus answers and tick behaviour.
 * Sees only top-level ports; select and hold state are shadowed from writes.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tps_defines.vh"
module tps_prescaler_sva #(
   parameter PRESC_WIDTH = 10
) (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic [3:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [3:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        ext_count_pin_a,
   input wire logic        ext_count_pin_b,
   input wire logic        timer_a_tick,
   input wire logic        timer_b_tick
);
   logic [2:0] selA, selB;
   logic [1:0] quiet;
   logic       halt, badW, goodW;
   wire        wrGo = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire        wrOk = wrGo && s_axi_wstrb[0];
   // Quiet counts edges since the last write so select changes settle first
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         selA  <= 3'h0;
         selB  <= 3'h0;
         halt  <= 1'b0;
         badW  <= 1'b0;
         goodW <= 1'b0;
         quiet <= 2'h0;
      end else begin
         if (wrGo) badW <= (s_axi_awaddr == 4'hC);
         if (wrGo) goodW <= (s_axi_awaddr == 4'h0) || (s_axi_awaddr == 4'h4);
         if (wrOk && s_axi_awaddr == 4'h4) selA <= s_axi_wdata[2:0];
         if (wrOk && s_axi_awaddr == 4'h4) selB <= s_axi_wdata[6:4];
         if (wrOk && s_axi_awaddr == 4'h0) halt <= s_axi_wdata[7] & s_axi_wdata[0];
         quiet <= wrGo ? 2'h0 : ((quiet == 2'h3) ? quiet : quiet + 2'h1);
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
   AST_BRESP_CODE: assert property ($rose(s_axi_bvalid) && (badW || goodW) |->
      s_axi_bresp == (badW ? `TPS_RESP_SLVERR : `TPS_RESP_OKAY)) else $error("bad write response");
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
      s_axi_rresp == (($past(s_axi_araddr) == 4'hC) ? `TPS_RESP_SLVERR : `TPS_RESP_OKAY))
      else $error("read answer late or wrong");
   AST_DIRECT_A: assert property (quiet == 2'h3 && selA == 3'h1 && !halt |-> timer_a_tick)
      else $error("direct tick missing");
   AST_STOP_B: assert property (quiet == 2'h3 && selB == 3'h0 |-> !timer_b_tick)
      else $error("stopped timer ticked");
   AST_TICK_PULSE_A: assert property (quiet == 2'h3 && selA > 3'h1 && timer_a_tick |=>
      !timer_a_tick) else $error("tick longer than one cycle");
   AST_DIV8_GAP_B: assert property (quiet == 2'h3 && selB == 3'h2 && timer_b_tick |=>
      !timer_b_tick [*7]) else $error("divide by 8 ticks too close");
   AST_EXT_RISE_A: assert property (quiet == 2'h3 && selA == 3'h7 && $rose(ext_count_pin_a)
      |-> ##[2:4] timer_a_tick) else $error("rising pin edge not ticked");
   AST_EXT_FALL_B: assert property (quiet == 2'h3 && selB == 3'h6 && $fell(ext_count_pin_b)
      |-> ##[2:4] timer_b_tick) else $error("falling pin edge not ticked");
   AST_HALT_B: assert property (quiet == 2'h3 && halt && selB inside {[3'h1:3'h5]}
      |-> !timer_b_tick) else $error("timer ran in hold mode");
endmodule
bind tps_prescaler_top tps_prescaler_sva #(.PRESC_WIDTH(PRESC_WIDTH)) i_sva (.ref_clk, .rst_n,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .ext_count_pin_a, .ext_count_pin_b,
   .timer_a_tick, .timer_b_tick);
`default_nettype wire

// ### tps_ext_clk_src.sv
/*
 * External clock source model for one count pin.
 * Assumes the bench starts and stops it only while no pin mode is changing.
 */
`timescale 1ns/100ps
`default_nettype none
module tps_ext_clk_src (
   input  wire logic       ref_clk,
   input  wire logic       run,
   input  wire logic [3:0] halfCycles,
   output var  logic       pin
);
   logic [3:0] cnt;
   initial begin
      pin = 1'b0;
      cnt = 4'h0;
   end
   // Halves under two cycles are stretched, or the sampler could miss a level
   always @(posedge ref_clk) begin
      if (!run) begin
         cnt <= 4'h0;
      end else if (cnt >= 4'h1 && cnt + 4'h1 >= halfCycles) begin
         cnt <= 4'h0;
         pin <= !pin;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ### tb_top.sv
/*
 * Bench for tps_prescaler_top: registers, tap rates, hold mode, pin ticks.
 * Assumes the checker is bound from its own file and two pin models.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tps_defines.vh"
module tb_top;
   logic        ref_clk, rst_n, runA, runB, chk, syncBad, pa, pb;
   logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        ext_count_pin_a, ext_count_pin_b, timer_a_tick, timer_b_tick, async_prescaler_reset;
   logic [9:0]  p1;
   int          miscompares, totalChecks, cyc, cntA, cntB, risesA, fallsB;
   int          c1, c2, a, b, e, f, i;
   int          divs[4] = '{8, 64, 256, 1024};
   tps_prescaler_top #(.PRESC_WIDTH(10)) i_dut (.*);
   tps_ext_clk_src i_srcA (.ref_clk, .run(runA), .halfCycles(4'h3), .pin(ext_count_pin_a));
   tps_ext_clk_src i_srcB (.ref_clk, .run(runB), .halfCycles(4'h2), .pin(ext_count_pin_b));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Counted on the falling edge so the main process never races them
   always @(negedge ref_clk) begin
      cyc++;
      cntA += timer_a_tick;
      cntB += timer_b_tick;
      risesA += ext_count_pin_a & !pa;
      fallsB += pb & !ext_count_pin_b;
      pa = ext_count_pin_a;
      pb = ext_count_pin_b;
      if (chk && timer_a_tick !== timer_b_tick) syncBad = 1'b1;
   end
   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic check(string name, logic [31:0] exp, logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic axiWrite(logic [3:0] ad, logic [31:0] dat, output logic [1:0] resp);
      logic awTk, wTk, bTk;
      @(posedge ref_clk);
      s_axi_awaddr  <= ad;
      s_axi_wdata   <= dat;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(negedge ref_clk);
         awTk = s_axi_awvalid && s_axi_awready;
         wTk  = s_axi_wvalid && s_axi_wready;
         bTk  = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge ref_clk);
         if (awTk) s_axi_awvalid <= 1'b0;
         if (wTk) s_axi_wvalid <= 1'b0;
      end while (!bTk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axiRead(logic [3:0] ad, output logic [31:0] dat, output logic [1:0] resp,
                          output int cy);
      logic arTk, rTk;
      @(posedge ref_clk);
      s_axi_araddr  <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(negedge ref_clk);
         arTk = s_axi_arvalid && s_axi_arready;
         if (arTk) cy = cyc;
         rTk  = s_axi_rvalid;
         dat  = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge ref_clk);
         if (arTk) s_axi_arvalid <= 1'b0;
      end while (!rTk);
      s_axi_rready <= 1'b0;
   endtask
   task automatic window(int n, output int ta, output int tb);
      ta = cntA;
      tb = cntB;
      repeat (n) @(posedge ref_clk);
      ta = cntA - ta;
      tb = cntB - tb;
   endtask
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_n, runA, runB, chk, syncBad, pa, pb} = 7'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_wstrb = 4'hF;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      axiRead(`TPS_OFF_SYNC_CTRL, d, r, c1);
      check("ctrl reset", 32'h0, d);
      axiRead(`TPS_OFF_SRC_SEL, d, r, c1);
      check("select reset", 32'h0, d);
      axiRead(4'hC, d, r, c1);
      check("unmapped read resp", `TPS_RESP_SLVERR, r);
      axiWrite(4'hC, 32'h0000_00FF, r);
      check("unmapped write resp", `TPS_RESP_SLVERR, r);
      axiRead(`TPS_OFF_STATUS, d, r, c1);
      p1 = d[9:0];
      axiRead(`TPS_OFF_STATUS, d, r, c2);
      check("prescaler advance", 10'(p1 + 10'(c2 - c1)), d[9:0]);
      axiWrite(`TPS_OFF_SYNC_CTRL, 32'h0000_0001, r);
      axiRead(`TPS_OFF_SYNC_CTRL, d, r, c1);
      check("shared reset self clear", 32'h0, d);
      for (i = 0; i < 4; i++) begin
         axiWrite(`TPS_OFF_SRC_SEL, 32'(i + 2) * 32'h11, r);
         window(2048, a, b);
         check("tap rate A", 2048 / divs[i], a);
         check("tap rate B", 2048 / divs[i], b);
      end
      axiWrite(`TPS_OFF_SRC_SEL, 32'h0000_0001, r);
      window(100, a, b);
      check("direct ticks A", 32'd100, a);
      check("stopped ticks B", 32'd0, b);
      s_axi_wstrb <= 4'hE;
      axiWrite(`TPS_OFF_SRC_SEL, 32'h0000_0077, r);
      s_axi_wstrb <= 4'hF;
      axiRead(`TPS_OFF_SRC_SEL, d, r, c1);
      check("write without low strobe", 32'h01, d);
      axiWrite(`TPS_OFF_SYNC_CTRL, 32'h0000_0083, r);
      axiWrite(`TPS_OFF_SRC_SEL, 32'h0000_0022, r);
      axiRead(`TPS_OFF_SYNC_CTRL, d, r, c1);
      check("hold keeps reset bits", 32'h83, d);
      window(100, a, b);
      check("held ticks", 32'd0, a + b);
      check("async reset held", 1'b1, async_prescaler_reset);
      chk = 1'b1;
      axiWrite(`TPS_OFF_SYNC_CTRL, 32'h0000_0000, r);
      window(7, a, b);
      check("no tick before restarted period", 32'd0, a + b);
      window(73, a, b);
      chk = 1'b0;
      check("timers start together", 1'b0, syncBad);
      check("async reset released", 1'b0, async_prescaler_reset);
      check("ticks after release", 32'd10, a);
      axiWrite(`TPS_OFF_SRC_SEL, 32'h0000_0067, r);
      e = risesA;
      f = fallsB;
      runA <= 1'b1;
      runB <= 1'b1;
      window(200, a, b);
      runA <= 1'b0;
      runB <= 1'b0;
      window(10, c1, c2);
      check("rising pin ticks", risesA - e, a + c1);
      check("falling pin ticks", fallsB - f, b + c2);
      stop_test;
   end
   // Full sequence takes about 8800 cycles; over twice that means a hang
   initial begin
      #400000;
      miscompares++;
      stop_test;
   end
endmodule
`default_nettype wire
